// ### design/tsl_limit_cmp.sv
// Limit comparator with hysteresis for the critical and high/low alarms.
// Assumes temperature_i and limits_i are on clk_i; alarms are level outputs.
`include "tsl_defines.svh"

module tsl_limit_cmp #(
	parameter int TEMP_W = 16
) (
	// Clock and reset
	input  wire logic               clk_i,
	input  wire logic               sys_rst_i,
	// Value and limits
	input  wire logic signed [15:0] temperature_i,
	input  tsl_pkg::tsl_limits_t    limits_i,
	// Alarms
	output logic                    crit_o,
	output logic                    limit_o
);
	import tsl_pkg::*;

	if (TEMP_W != 16) begin : g_chk
		$error("tsl_limit_cmp: only 16-bit words supported");
	end

	logic               over_q, under_q;
	logic               next_crit, next_over, next_under;
	logic signed [16:0] hyst_w, temp_w;

	// One extra bit keeps limit minus hysteresis from wrapping
	function automatic logic signed [16:0] wide(input logic signed [15:0] v);
		return {v[15], v};
	endfunction

	assign hyst_w = signed'(17'(limits_i.hyst) << `TSL_DEG_SHIFT);
	assign temp_w = wide(temperature_i);

	always_comb begin
		next_crit  = crit_o;
		next_over  = over_q;
		next_under = under_q;
		if (temp_w > wide(limits_i.crit))
			next_crit = 1'b1;
		else if (temp_w < wide(limits_i.crit) - hyst_w)
			next_crit = 1'b0;
		if (temp_w > wide(limits_i.high))
			next_over = 1'b1;
		else if (temp_w < wide(limits_i.high) - hyst_w)
			next_over = 1'b0;
		if (temp_w < wide(limits_i.low))
			next_under = 1'b1;
		else if (temp_w > wide(limits_i.low) + hyst_w)
			next_under = 1'b0;
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			crit_o  <= 1'b0;
			over_q  <= 1'b0;
			under_q <= 1'b0;
			limit_o <= 1'b0;
		end else begin
			crit_o  <= next_crit;
			over_q  <= next_over;
			under_q <= next_under;
			limit_o <= next_over | next_under;
		end
	end
endmodule // tsl_limit_cmp

// ### design/tsl_pin_sync.sv
// Synchroniser and edge finder for the SCL and SDA pins.
// Assumes both pins idle high and change far slower than clk_i.
module tsl_pin_sync #(
	parameter int STAGES = 2
) (
	// Clock and reset
	input  wire logic           clk_i,
	input  wire logic           sys_rst_i,
	// Pins
	input  wire logic           scl_i,
	input  wire logic           sda_i,
	// Bus events
	output tsl_pkg::tsl_bus_evt_t evt_o
);
	import tsl_pkg::*;

	if (STAGES < 2) begin : g_chk
		$error("tsl_pin_sync: at least two stages needed");
	end

	logic [STAGES-1:0] scl_sh, sda_sh;
	logic              scl_prev, sda_prev;

	// Edges are taken from the last stage only, never from the first
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			scl_sh   <= '1;
			sda_sh   <= '1;
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
		end else begin
			scl_sh   <= {scl_sh[STAGES-2:0], scl_i};
			sda_sh   <= {sda_sh[STAGES-2:0], sda_i};
			scl_prev <= scl_sh[STAGES-1];
			sda_prev <= sda_sh[STAGES-1];
		end
	end

	always_comb begin
		evt_o.scl      = scl_sh[STAGES-1];
		evt_o.sda      = sda_sh[STAGES-1];
		evt_o.scl_rise = scl_sh[STAGES-1] & ~scl_prev;
		evt_o.scl_fall = ~scl_sh[STAGES-1] & scl_prev;
		evt_o.start    = scl_sh[STAGES-1] & scl_prev & sda_prev & ~sda_sh[STAGES-1];
		evt_o.stop     = scl_sh[STAGES-1] & scl_prev & ~sda_prev & sda_sh[STAGES-1];
	end
endmodule // tsl_pin_sync

// ### design/tsl_top.sv
// Serial target of the temperature sensor: pointer, limit registers, bus engine, alarms.
// Assumes temperature_i comes from conversion logic on clk_i; SDA is open drain and
// is resolved outside from sda_oe_o; SCL is only ever read.
// Overview of operation
// - Critical alarm when temperature exceeds critical limit
// - Limits held as signed two's complement words
// - Critical pair read at 0x08 then 0x09
// - Critical limit resets to 0x49, 0x80
// - High limit resets to 0x20, 0x00
// - Low limit resets to 0x05, 0x00
// - Hysteresis is four unsigned whole-degree bits
// - Release thresholds offset by hysteresis value
// - Hysteresis resets to five, upper nibble zero
// - Identification byte is read only
// - Address is 10010 plus two strap pins
// - Target only, never starts a transfer
// - Acknowledge own address, else wait START
// - Direction zero writes, one reads
// - Nine clocks per byte, receiver acknowledges
// - SDA changes only while SCL low
// - Direction fixed for whole transaction
// - Limit alarm above high or below low
// - Pointer steps only upper to lower byte
// - Extra written bytes are ignored
`include "tsl_defines.svh"

module tsl_top #(
	parameter logic [4:0] MAKER_CODE = 5'h0A, // Arbitrary value
	parameter logic [2:0] REVISION   = 3'h1   // Arbitrary value
) (
	// Clock and reset
	input  wire logic               clk_i,
	input  wire logic               sys_rst_i,
	// Serial bus pins
	input  wire logic               scl_i,
	input  wire logic               sda_i,
	output logic                    sda_o,
	output logic                    sda_oe_o,
	// Address straps
	input  wire logic               address_strap_bit_zero_i,
	input  wire logic               address_strap_bit_one_i,
	// Conversion result
	input  wire logic signed [15:0] temperature_i,
	// Alarms
	output logic                    critical_alarm_output_o,
	output logic                    limit_alarm_output_o
);
	import tsl_pkg::*;

	// ==========================================================
	// Declarations
	tsl_bus_evt_t evt;
	tsl_limits_t  lim;
	tsl_state_t   state, next_state;
	logic [3:0]   bit_cnt;
	logic [7:0]   rx_sh, tx_sh, ptr, ld_ptr, ld_byte, wr_ptr;
	logic [7:0]   lim_q [`TSL_N_REGS];
	logic [1:0]   byte_idx;
	logic [1:0]   strap_m, strap_s;
	logic         byte_done, addr_hit, mack, dir_rd, wr_ok;
	logic         after_rst;
	logic [7:0]   id_byte;

	assign id_byte = {MAKER_CODE, REVISION};

	// ==========================================================
	// Register decode helpers
	function automatic logic [2:0] reg_idx(input logic [7:0] p);
		return 3'(p - `TSL_OFS_HIGH_MSB);
	endfunction

	function automatic logic writable(input logic [7:0] p);
		return (p >= `TSL_OFS_HIGH_MSB) && (p <= `TSL_OFS_HYST);
	endfunction

	function automatic logic is_msb(input logic [7:0] p);
		return (p == `TSL_OFS_HIGH_MSB) || (p == `TSL_OFS_LOW_MSB) || (p == `TSL_OFS_CRIT_MSB);
	endfunction

	// Only the upper byte of a pair moves on; every other offset stays put
	function automatic logic [7:0] next_ptr(input logic [7:0] p);
		return is_msb(p) ? p + 8'h01 : p;
	endfunction

	function automatic logic [7:0] reset_byte(input logic [2:0] i);
		case (i)
			reg_idx(`TSL_OFS_HIGH_MSB): return `TSL_RST_HIGH_MSB;
			reg_idx(`TSL_OFS_HIGH_LSB): return `TSL_RST_HIGH_LSB;
			reg_idx(`TSL_OFS_LOW_MSB):  return `TSL_RST_LOW_MSB;
			reg_idx(`TSL_OFS_LOW_LSB):  return `TSL_RST_LOW_LSB;
			reg_idx(`TSL_OFS_CRIT_MSB): return `TSL_RST_CRIT_MSB;
			reg_idx(`TSL_OFS_CRIT_LSB): return `TSL_RST_CRIT_LSB;
			default:                    return {`TSL_HYST_HI_ZERO, `TSL_RST_HYST};
		endcase
	endfunction

	// ==========================================================
	// Pin synchronisers
	tsl_pin_sync #(
		.STAGES (2)
	) u_sync (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.scl_i     (scl_i),
		.sda_i     (sda_i),
		.evt_o     (evt)
	);

	// Straps are pins too, so they cross two flops before the compare
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			strap_m <= 2'h0;
			strap_s <= 2'h0;
		end else begin
			strap_m <= {address_strap_bit_one_i, address_strap_bit_zero_i};
			strap_s <= strap_m;
		end
	end

	// ==========================================================
	// Bus engine
	assign byte_done = (bit_cnt == `TSL_BYTE_BITS);
	assign addr_hit  = (rx_sh[7:1] == {`TSL_ADDR_FIXED, strap_s});
	assign ld_ptr    = (state == ST_RD_ACK) ? next_ptr(ptr) : ptr;
	assign wr_ptr    = (byte_idx == `TSL_BIDX_DATA1) ? ptr : ptr + 8'h01;
	assign wr_ok     = (byte_idx == `TSL_BIDX_DATA1) ? writable(ptr)
	                 : (byte_idx == `TSL_BIDX_DATA2) && is_msb(ptr);

	always_comb begin
		if (ld_ptr >= `TSL_OFS_HIGH_MSB && ld_ptr <= `TSL_OFS_CRIT_LSB)
			ld_byte = lim_q[reg_idx(ld_ptr)];
		else if (ld_ptr == `TSL_OFS_HYST)
			ld_byte = {`TSL_HYST_HI_ZERO, lim_q[reg_idx(ld_ptr)][3:0]};
		else if (ld_ptr == `TSL_OFS_ID)
			ld_byte = id_byte;
		else
			ld_byte = 8'h00;
	end

	// The engine only answers; it never creates START or STOP itself
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: next_state = ST_IDLE;
			ST_ADDR: begin
				if (evt.scl_fall && byte_done)
					next_state = addr_hit ? ST_ADDR_ACK : ST_IDLE;
			end
			ST_ADDR_ACK: begin
				if (evt.scl_fall)
					next_state = dir_rd ? ST_READ : ST_WRITE;
			end
			ST_WRITE: begin
				if (evt.scl_fall && byte_done)
					next_state = ST_WR_ACK;
			end
			ST_WR_ACK: begin
				if (evt.scl_fall)
					next_state = ST_WRITE;
			end
			ST_READ: begin
				if (evt.scl_fall && byte_done)
					next_state = ST_RD_ACK;
			end
			ST_RD_ACK: begin
				if (evt.scl_fall)
					next_state = mack ? ST_READ : ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase
		if (evt.stop)
			next_state = ST_IDLE;
		else if (evt.start)
			next_state = ST_ADDR;
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	// Bit count restarts on START and after every acknowledge slot
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			bit_cnt <= 4'h0;
		end else if (evt.start || (evt.scl_fall && (state == ST_ADDR_ACK || state == ST_WR_ACK
		             || state == ST_RD_ACK))) begin
			bit_cnt <= 4'h0;
		end else if (evt.scl_rise && (state == ST_ADDR || state == ST_WRITE || state == ST_READ)) begin
			bit_cnt <= bit_cnt + 4'h1;
		end
	end

	// Data is sampled on the rising edge, while SCL is high and SDA stable
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rx_sh <= 8'h00;
			mack  <= 1'b0;
		end else if (evt.scl_rise) begin
			if (state == ST_ADDR || state == ST_WRITE)
				rx_sh <= {rx_sh[6:0], evt.sda};
			if (state == ST_RD_ACK)
				mack <= ~evt.sda;
		end
	end

	// Direction is latched once per transaction from the address byte
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			dir_rd <= 1'b0;
		else if (state == ST_ADDR && evt.scl_fall && byte_done && addr_hit)
			dir_rd <= rx_sh[0];
	end

	// SDA is moved on a falling SCL edge and released on START or STOP; a released line reads high
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sda_oe_o <= 1'b0;
			tx_sh    <= 8'h00;
		end else if (evt.stop || evt.start) begin
			sda_oe_o <= 1'b0;
		end else if (evt.scl_fall) begin
			case (state)
				ST_ADDR: sda_oe_o <= byte_done && addr_hit;
				ST_WRITE: sda_oe_o <= byte_done;
				ST_ADDR_ACK, ST_RD_ACK: begin
					if (next_state == ST_READ) begin
						tx_sh    <= ld_byte;
						sda_oe_o <= ~ld_byte[7];
					end else begin
						sda_oe_o <= 1'b0;
					end
				end
				ST_READ: begin
					if (byte_done) begin
						sda_oe_o <= 1'b0;
					end else begin
						tx_sh    <= {tx_sh[6:0], 1'b0};
						sda_oe_o <= ~tx_sh[6];
					end
				end
				default: sda_oe_o <= 1'b0;
			endcase
		end
	end

	// Open-drain data: the driven level is always low
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			sda_o <= 1'b0;
		else
			sda_o <= 1'b0;
	end

	// ==========================================================
	// Pointer and register file
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			byte_idx <= `TSL_BIDX_PTR;
		else if (state == ST_ADDR_ACK)
			byte_idx <= `TSL_BIDX_PTR;
		else if (state == ST_WRITE && evt.scl_fall && byte_done && byte_idx != `TSL_BIDX_EXTRA)
			byte_idx <= byte_idx + 2'h1;
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			ptr <= 8'h00;
		else if (state == ST_WRITE && evt.scl_fall && byte_done && byte_idx == `TSL_BIDX_PTR)
			ptr <= rx_sh;
		else if (state == ST_RD_ACK && evt.scl_fall && mack)
			ptr <= ld_ptr;
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			for (int i = 0; i < `TSL_N_REGS; i++)
				lim_q[i] <= reset_byte(3'(i));
		end else if (state == ST_WRITE && evt.scl_fall && byte_done && wr_ok) begin
			if (wr_ptr == `TSL_OFS_HYST)
				lim_q[reg_idx(wr_ptr)] <= {`TSL_HYST_HI_ZERO, rx_sh[3:0]};
			else
				lim_q[reg_idx(wr_ptr)] <= rx_sh;
		end
	end

	// ==========================================================
	// Limit comparison
	always_comb begin
		lim.high = signed'({lim_q[reg_idx(`TSL_OFS_HIGH_MSB)], lim_q[reg_idx(`TSL_OFS_HIGH_LSB)]});
		lim.low  = signed'({lim_q[reg_idx(`TSL_OFS_LOW_MSB)], lim_q[reg_idx(`TSL_OFS_LOW_LSB)]});
		lim.crit = signed'({lim_q[reg_idx(`TSL_OFS_CRIT_MSB)], lim_q[reg_idx(`TSL_OFS_CRIT_LSB)]});
		lim.hyst = lim_q[reg_idx(`TSL_OFS_HYST)][3:0];
	end

	tsl_limit_cmp #(
		.TEMP_W (16)
	) u_cmp (
		.clk_i         (clk_i),
		.sys_rst_i     (sys_rst_i),
		.temperature_i (temperature_i),
		.limits_i      (lim),
		.crit_o        (critical_alarm_output_o),
		.limit_o       (limit_alarm_output_o)
	);

	// ==========================================================
	// Assertions
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			after_rst <= 1'b0;
		else
			after_rst <= 1'b1;
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	crit_reset_a: assert property (
		!after_rst |-> lim.crit == signed'({`TSL_RST_CRIT_MSB, `TSL_RST_CRIT_LSB}))
		else $error("critical limit reset value wrong");
	high_reset_a: assert property (
		!after_rst |-> lim.high == signed'({`TSL_RST_HIGH_MSB, `TSL_RST_HIGH_LSB}))
		else $error("high limit reset value wrong");
	low_reset_a: assert property (
		!after_rst |-> lim.low == signed'({`TSL_RST_LOW_MSB, `TSL_RST_LOW_LSB}))
		else $error("low limit reset value wrong");
	hyst_reset_a: assert property (
		!after_rst |-> lim.hyst == `TSL_RST_HYST && lim_q[reg_idx(`TSL_OFS_HYST)][7:4] == `TSL_HYST_HI_ZERO)
		else $error("hysteresis reset value wrong");
	crit_alarm_a: assert property (
		temperature_i > lim.crit |=> critical_alarm_output_o)
		else $error("critical alarm missed");
	crit_release_a: assert property (
		critical_alarm_output_o && $signed({temperature_i[15], temperature_i}) >= $signed({lim.crit[15], lim.crit})
			- $signed(17'(lim.hyst) << `TSL_DEG_SHIFT) && $stable(lim) |=> critical_alarm_output_o)
		else $error("critical alarm released inside hysteresis band");
	limit_alarm_a: assert property (
		(temperature_i > lim.high || temperature_i < lim.low) |=> limit_alarm_output_o)
		else $error("limit alarm missed");
	addr_ack_a: assert property (
		state == ST_ADDR && evt.scl_fall && byte_done && addr_hit && !evt.start && !evt.stop
			|=> sda_oe_o && state == ST_ADDR_ACK)
		else $error("own address not acknowledged");
	addr_miss_a: assert property (
		state == ST_ADDR && evt.scl_fall && byte_done && !addr_hit && !evt.start
			|=> !sda_oe_o && state == ST_IDLE)
		else $error("foreign address acknowledged");
	idle_quiet_a: assert property (
		state == ST_IDLE && $past(state) == ST_IDLE |-> !sda_oe_o)
		else $error("target drove SDA while idle");
	sda_scl_low_a: assert property (
		$changed(sda_oe_o) && !$past(evt.start) && !$past(evt.stop) |-> !$past(evt.scl))
		else $error("SDA moved while SCL high");
	dir_read_a: assert property (
		state == ST_ADDR_ACK && dir_rd && evt.scl_fall && !evt.stop && !evt.start |=> state == ST_READ)
		else $error("read direction not honoured");
	dir_fixed_a: assert property (
		state == ST_WRITE |=> state inside {ST_WRITE, ST_WR_ACK, ST_IDLE, ST_ADDR})
		else $error("write changed into read without START");
	ptr_step_a: assert property (
		$changed(ptr) && $past(state) == ST_RD_ACK |-> ptr == $past(ptr) + 8'h01 && is_msb($past(ptr)))
		else $error("pointer stepped outside a 16-bit pair");
	extra_byte_a: assert property (
		state == ST_WRITE && evt.scl_fall && byte_done && byte_idx == `TSL_BIDX_EXTRA |=> $stable(lim))
		else $error("extra data byte altered a register");
	id_read_a: assert property (
		state == ST_ADDR_ACK && evt.scl_fall && dir_rd && ptr == `TSL_OFS_ID && !evt.stop && !evt.start
			|=> tx_sh == id_byte)
		else $error("identification byte wrong");

	addr_ack_c: cover property (state == ST_ADDR_ACK && evt.scl_fall);
	pair_read_c: cover property (state == ST_RD_ACK && evt.scl_fall && mack && ptr == `TSL_OFS_CRIT_MSB);
	two_write_c: cover property (state == ST_WRITE && evt.scl_fall && byte_done && byte_idx == `TSL_BIDX_DATA2);
	crit_rise_c: cover property ($rose(critical_alarm_output_o));
endmodule // tsl_top

// ### pkg/tsl_defines.svh
// Register offsets, reset values and bus constants of the temperature sensor target.
// Included by every design file that decodes the register map.
`ifndef TSL_DEFINES_SVH
`define TSL_DEFINES_SVH
`define TSL_OFS_HIGH_MSB  8'h04
`define TSL_OFS_HIGH_LSB  8'h05
`define TSL_OFS_LOW_MSB   8'h06
`define TSL_OFS_LOW_LSB   8'h07
`define TSL_OFS_CRIT_MSB  8'h08
`define TSL_OFS_CRIT_LSB  8'h09
`define TSL_OFS_HYST      8'h0A
`define TSL_OFS_ID        8'h0B
`define TSL_RST_HIGH_MSB  8'h20
`define TSL_RST_HIGH_LSB  8'h00
`define TSL_RST_LOW_MSB   8'h05
`define TSL_RST_LOW_LSB   8'h00
`define TSL_RST_CRIT_MSB  8'h49
`define TSL_RST_CRIT_LSB  8'h80
`define TSL_RST_HYST      4'h5
`define TSL_HYST_HI_ZERO  4'h0
`define TSL_ADDR_FIXED    5'h12
`define TSL_BYTE_BITS     4'h8
`define TSL_DEG_SHIFT     7
`define TSL_BIDX_PTR      2'h0
`define TSL_BIDX_DATA1    2'h1
`define TSL_BIDX_DATA2    2'h2
`define TSL_BIDX_EXTRA    2'h3
`define TSL_N_REGS        7
`endif

// ### pkg/tsl_pkg.sv
// Types shared by the temperature sensor target modules.
// Assumes nothing of its surroundings.
package tsl_pkg;
	typedef enum logic [2:0] {
		ST_IDLE     = 3'b000,
		ST_ADDR     = 3'b001,
		ST_ADDR_ACK = 3'b010,
		ST_WRITE    = 3'b011,
		ST_WR_ACK   = 3'b100,
		ST_READ     = 3'b101,
		ST_RD_ACK   = 3'b110
	} tsl_state_t;

	typedef struct packed {
		logic scl;
		logic sda;
		logic scl_rise;
		logic scl_fall;
		logic start;
		logic stop;
	} tsl_bus_evt_t;

	typedef struct packed {
		logic signed [15:0] high;
		logic signed [15:0] low;
		logic signed [15:0] crit;
		logic [3:0]         hyst;
	} tsl_limits_t;
endpackage

// ### test/tsl_i2c_ctrl.sv
// Serial bus controller model that drives the sensor's SCL and SDA pins.
// Assumes SDA is resolved outside with a pull-up; SCL idles high between frames.
module tsl_i2c_ctrl (
	// Bus lines
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_pull_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// Quarter of the 125 ns bit period
	localparam real Q = 31.25;

	initial begin
		scl_o = 1'b1;
		sda_pull_o = 1'b0;
	end

	// ====================
	// Bus conditions
	// Works from idle and as a repeated start with SCL low
	task automatic bus_start;
		#(Q) sda_pull_o <= 1'b0;
		#(Q) scl_o <= 1'b1;
		#(Q) sda_pull_o <= 1'b1;
		#(Q) scl_o <= 1'b0;
	endtask

	task automatic bus_stop;
		#(Q) sda_pull_o <= 1'b1;
		#(Q) scl_o <= 1'b1;
		#(Q) sda_pull_o <= 1'b0;
		#(Q);
	endtask

	// ====================
	// Bits and bytes
	// Data moves only in the low half; sampled mid-high
	task automatic clk_bit(input logic b, output logic s);
		#(Q) sda_pull_o <= ~b;
		#(Q) scl_o <= 1'b1;
		#(Q) s = sda_i;
		#(Q) scl_o <= 1'b0;
	endtask

	task automatic xfer_byte(input logic [7:0] tx, input logic ack_tx, output logic [7:0] rx, output logic ack_rx);
		for (int i = 7; i >= 0; i--) clk_bit(tx[i], rx[i]);
		clk_bit(ack_tx, ack_rx);
		ack_rx = ~ack_rx;
	endtask

	// ====================
	// Transactions
	// A refused address ends the frame at once
	task automatic wr(input logic [6:0] a, input logic [7:0] d[$], output logic ack);
		logic [7:0] r;
		logic       k;
		bus_start();
		xfer_byte({a, 1'b0}, 1'b1, r, ack);
		foreach (d[i]) begin
			if (ack) begin
				xfer_byte(d[i], 1'b1, r, k);
				ack = ack & k;
			end
		end
		bus_stop();
	endtask

	// The last byte read gets a NACK before the stop
	task automatic rd(input logic [6:0] a, input int n, output logic [7:0] q[$], output logic ack);
		logic [7:0] r;
		logic       k;
		q = {};
		bus_start();
		xfer_byte({a, 1'b1}, 1'b1, r, ack);
		for (int i = 0; i < n; i++) begin
			if (ack) begin
				xfer_byte(8'hFF, (i == n - 1), r, k);
				q.push_back(r);
			end
		end
		bus_stop();
	endtask
endmodule // tsl_i2c_ctrl

// ### test/tsl_top_bench.sv
// Self-checking bench of the sensor target: register map, bus address, alarms.
// Assumes the controller model tsl_i2c_ctrl and a pull-up on SDA.
module tsl_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import tsl_pkg::*;

	localparam logic [4:0] MAKER = 5'h0C; // Arbitrary value
	localparam logic [2:0] REV   = 3'h2;  // Arbitrary value
	localparam logic [7:0] ID    = {MAKER, REV};
	localparam logic [7:0] OFS [7] = '{8'h04, 8'h06, 8'h08, 8'h05, 8'h0A, 8'h0B, 8'h02};
	localparam logic [7:0] E0 [7]  = '{8'h20, 8'h05, 8'h49, 8'h00, 8'h05, ID, 8'h00};
	localparam logic [7:0] E1 [7]  = '{8'h00, 8'h00, 8'h80, 8'h00, 8'h05, ID, 8'h00};
	localparam logic signed [15:0] TT [11] = '{16'sh0C00, 16'sh8000, 16'sh0700, 16'sh0C00, 16'sh2001,
		16'sh1E00, 16'sh1D00, 16'sh4981, 16'sh4800, 16'sh4600, 16'sh0C00};
	localparam logic [10:0] EC = 11'h180;
	localparam logic [10:0] EL = 11'h3B6;

	logic               clk_i = 1'b0;
	logic               sys_rst_i = 1'b1;
	logic [1:0]         strap = 2'h0;
	logic signed [15:0] temp = 16'sh0C00;
	logic               scl;
	logic               sda_pull;
	logic               sda_o;
	logic               sda_oe_o;
	logic               crit;
	logic               lim;
	logic               ack;
	logic [7:0]         q[$];
	int                 fails = 0;
	int                 n_compared = 0;
	// Open-drain wire with pull-up
	wire                sda = ~(sda_pull | (sda_oe_o & ~sda_o));

	always #4 clk_i = ~clk_i;

	tsl_top #(.MAKER_CODE(MAKER), .REVISION(REV)) i_dut (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
		.address_strap_bit_zero_i(strap[0]), .address_strap_bit_one_i(strap[1]), .temperature_i(temp),
		.critical_alarm_output_o(crit), .limit_alarm_output_o(lim));

	tsl_i2c_ctrl i_ctrl (.sda_i(sda), .scl_o(scl), .sda_pull_o(sda_pull));

	// ====================
	// Compare and report
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmp1(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic give_verdict;
		if (fails == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Set the pointer, then read two bytes back
	task automatic chk_reg(input logic [7:0] ofs, input logic [7:0] e0, input logic [7:0] e1);
		i_ctrl.wr(7'h48, {ofs}, ack);
		cmp1(ack, 1'b1);
		i_ctrl.rd(7'h48, 2, q, ack);
		cmp1(ack, 1'b1);
		cmp8(q[0], e0);
		cmp8(q[1], e1);
	endtask

	task automatic set_temp(input logic signed [15:0] t);
		@(posedge clk_i);
		temp <= t;
		repeat (4) @(posedge clk_i);
	endtask

	// A hung run still ends in the verdict
	initial begin
		repeat (80000) @(posedge clk_i);
		fails++;
		give_verdict();
	end

	// ====================
	// Main sequence
	initial begin
		repeat (6) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		repeat (10) @(posedge clk_i);
		for (int i = 0; i < 7; i++) chk_reg(OFS[i], E0[i], E1[i]);
		foreach (TT[i]) begin
			set_temp(TT[i]);
			cmp1(crit, EC[i]);
			cmp1(lim, EL[i]);
		end
		// Third data byte must not spill into the next register
		i_ctrl.wr(7'h48, {8'h08, 8'h12, 8'h34, 8'h56}, ack);
		cmp1(ack, 1'b1);
		chk_reg(8'h08, 8'h12, 8'h34);
		chk_reg(8'h0A, 8'h05, 8'h05);
		i_ctrl.wr(7'h48, {8'h0A, 8'hFF}, ack);
		chk_reg(8'h0A, 8'h0F, 8'h0F);
		i_ctrl.wr(7'h48, {8'h0B, 8'hA5}, ack);
		chk_reg(8'h0B, ID, ID);
		i_ctrl.wr(7'h48, {8'h04, 8'h9A}, ack);
		chk_reg(8'h04, 8'h9A, 8'h00);
		i_ctrl.wr(7'h48, {8'h06, 8'hC3, 8'h5E}, ack);
		chk_reg(8'h06, 8'hC3, 8'h5E);
		// High and low limits are now negative words
		set_temp(16'sh1235);
		cmp1(crit, 1'b1);
		cmp1(lim, 1'b1);
		for (int s = 0; s < 4; s++) begin
			@(posedge clk_i);
			strap <= s[1:0];
			repeat (8) @(posedge clk_i);
			for (int a = 0; a < 4; a++) begin
				i_ctrl.wr(7'h48 + a[6:0], {8'h0B}, ack);
				cmp1(ack, a == s);
			end
		end
		give_verdict();
	end
endmodule // tsl_top_bench
